// ### hdl/control_register_move.sv
// Control-register move execution unit
`timescale 1ns/1ps
`default_nettype none
module control_register_move #(
    parameter int DEPTH_W = 4
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        op_valid,      // Issue strobe
    output logic             op_ready_r,    // Unit idle
    input  wire logic        op_load,       // 1: into control register
    input  wire logic [2:0]  op_mode,       // Operand mode
    input  wire logic [6:0]  op_sel,        // Control register code
    input  wire logic        op_space,      // 0: X memory, 1: Y memory
    input  wire logic [2:0]  op_areg,       // Address register number
    input  wire logic [31:0] op_reg_data,   // Source register value
    input  wire logic [31:0] ea_value,      // Address unit result for op_areg
    output logic [2:0]       areg_sel_r,    // Address register in use
    output logic             ext_req_r,     // Extension word wanted
    input  wire logic        ext_valid,
    input  wire logic [31:0] ext_word,
    output logic             mem_req_r,
    output logic             mem_we_r,
    output logic             mem_space_r,
    output logic [31:0]      mem_addr_r,
    output logic [31:0]      mem_wdata_r,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic             dst_valid_r,   // Register destination written
    output logic [31:0]      dst_data_r,
    output logic             done_r,        // Instruction finished
    output logic             error_r,       // Illegal mode or code
    output logic [1:0]       words_r,       // Program words used
    output logic [31:0]      status_word_r,
    output logic [31:0]      operating_mode_word_r,
    output logic [31:0]      stack_pointer_r,
    output logic [31:0]      loop_address_r,
    output logic [31:0]      loop_count_r
);
    // ==========================================================
    // Decode of the issued instruction
    mcr_pkg::state_type state_r;       // Controller state
    mcr_pkg::state_type state_nxt;
    logic               load_r;        // Direction held for the instruction
    logic [2:0]         mode_r;        // Operand mode held
    logic [6:0]         sel_r;         // Control register held
    logic [31:0]        src_r;         // Source word gathered
    logic [31:0]        ext_r;         // Extension word captured

    // Only codes of the seven controller registers are accepted
    function automatic logic is_ctrl(input logic [6:0] s);
        is_ctrl = (s >= mcr_pkg::SEL_STATUS);
    endfunction : is_ctrl

    // Modes needing an extension word after the opcode
    function automatic logic has_ext(input logic [2:0] m);
        has_ext = (m == mcr_pkg::MODE_IMM) || (m == mcr_pkg::MODE_DISP)
               || (m == mcr_pkg::MODE_ABS);
    endfunction : has_ext

    wire accept   = (state_r == mcr_pkg::ST_IDLE) && op_valid;
    wire mode_ok  = (op_mode <= mcr_pkg::MODE_ABS);
    wire bad_op   = !mode_ok || !is_ctrl(op_sel);
    wire in_exec  = (state_r == mcr_pkg::ST_EXEC);
    wire wr_ctrl  = in_exec && load_r;
    wire sel_ssh  = (sel_r == mcr_pkg::SEL_SHIGH);
    wire wr_stat  = wr_ctrl && (sel_r == mcr_pkg::SEL_STATUS);
    wire pop      = in_exec && !load_r && sel_ssh;
    wire push     = wr_ctrl && sel_ssh;

    // ==========================================================
    // System stack
    wire [DEPTH_W-1:0] sp_idx   = stack_pointer_r[DEPTH_W-1:0];
    wire [DEPTH_W-1:0] sp_inc   = DEPTH_W'(sp_idx + 1'b1);
    logic [31:0]       stk_high;
    logic [31:0]       stk_low;

    // pushed slot is pointer plus one
    mcr_stack #(.DEPTH_W(DEPTH_W)) u_stack (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .rd_idx     (sp_idx),
        .rd_high    (stk_high),
        .rd_low     (stk_low),
        .wr_idx     (push ? sp_inc : sp_idx),
        .wr_high_en (push),
        .wr_low_en  (wr_ctrl && (sel_r == mcr_pkg::SEL_SLOW)),
        .wr_data    (src_r)
    );

    // ==========================================================
    // Control register read selection
    // any controller register readable
    wire [31:0] ctrl_rd =
        (sel_r == mcr_pkg::SEL_STATUS) ? status_word_r :
        (sel_r == mcr_pkg::SEL_OPMODE) ? operating_mode_word_r :
        (sel_r == mcr_pkg::SEL_SPTR)   ? stack_pointer_r :
        (sel_r == mcr_pkg::SEL_SHIGH)  ? stk_high :
        (sel_r == mcr_pkg::SEL_SLOW)   ? stk_low :
        (sel_r == mcr_pkg::SEL_LADDR)  ? loop_address_r :
                                         loop_count_r;

    // base plus displacement; the address-unit mode takes base alone
    wire [31:0] addr_calc = (mode_r == mcr_pkg::MODE_DISP) ? ea_value + ext_r : ea_value;

    // field placement of a status load
    wire [31:0] stat_nxt = src_r;

    // ==========================================================
    // Next state: extension fetch, address, memory, execute
    // least path is accept then execute, extras per mode
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            mcr_pkg::ST_IDLE:
                if (op_valid && !bad_op)
                begin
                    if (has_ext(op_mode))
                        state_nxt = mcr_pkg::ST_FETCH;
                    else if (op_mode == mcr_pkg::MODE_EA)
                        state_nxt = mcr_pkg::ST_ADDR;
                    else
                        state_nxt = mcr_pkg::ST_EXEC;
                end
            mcr_pkg::ST_FETCH:
                if (ext_valid)
                begin
                    if (mode_r == mcr_pkg::MODE_IMM)
                        state_nxt = mcr_pkg::ST_EXEC;
                    else if (mode_r == mcr_pkg::MODE_DISP)
                        state_nxt = mcr_pkg::ST_ADDR;
                    else
                        state_nxt = mcr_pkg::ST_MEM;
                end
            mcr_pkg::ST_ADDR:
                state_nxt = mcr_pkg::ST_MEM;
            mcr_pkg::ST_MEM:
                if (mem_ack)
                    state_nxt = mcr_pkg::ST_EXEC;
            default:
                state_nxt = mcr_pkg::ST_IDLE;
        endcase
    end

    // Sequencer and handshake flops
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r    <= mcr_pkg::ST_IDLE;
            op_ready_r <= 1'b0;
            ext_req_r  <= 1'b0;
            mem_req_r  <= 1'b0;
            done_r     <= 1'b0;
            error_r    <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r    <= state_nxt;
            op_ready_r <= (state_nxt == mcr_pkg::ST_IDLE);
            ext_req_r  <= (state_nxt == mcr_pkg::ST_FETCH);
            mem_req_r  <= (state_nxt == mcr_pkg::ST_MEM);
            done_r     <= in_exec;
            error_r    <= accept && bad_op;
        end
    end

    // Operand capture
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_r     <= 1'b0;
            mode_r     <= mcr_pkg::MODE_REG;
            sel_r      <= mcr_pkg::SEL_STATUS;
            areg_sel_r <= 3'h0;
            words_r    <= mcr_pkg::BASE_WORDS;
            src_r      <= mcr_pkg::RST_WORD;
            ext_r      <= mcr_pkg::RST_WORD;
        end
        else if (clk_en)
        begin
            if (accept && !bad_op)
            begin
                load_r     <= op_load;
                mode_r     <= op_mode;
                sel_r      <= op_sel;
                areg_sel_r <= op_areg;
                words_r    <= mcr_pkg::BASE_WORDS + {1'b0, has_ext(op_mode)};
                src_r      <= op_reg_data;
            end
            else if (state_r == mcr_pkg::ST_FETCH && ext_valid)
            begin
                ext_r <= ext_word;
                if (mode_r == mcr_pkg::MODE_IMM)
                    src_r <= ext_word;
            end
            else if (state_r == mcr_pkg::ST_MEM && mem_ack && !mem_we_r)
                src_r <= mem_rdata;
        end
    end

    // Memory access port
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_we_r    <= 1'b0;
            mem_space_r <= 1'b0;
            mem_addr_r  <= mcr_pkg::RST_WORD;
            mem_wdata_r <= mcr_pkg::RST_WORD;
        end
        else if (clk_en)
        begin
            if (accept)
            begin
                mem_we_r    <= !op_load;
                mem_space_r <= op_space;
            end
            // absolute address straight from the word
            if (state_r == mcr_pkg::ST_FETCH && ext_valid)
                mem_addr_r <= ext_word;
            else if (state_r == mcr_pkg::ST_ADDR)
                mem_addr_r <= addr_calc;
            // Stack high is sampled before the pop in execute
            if (state_nxt == mcr_pkg::ST_MEM)
                mem_wdata_r <= ctrl_rd;
        end
    end

    // Register destination result
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dst_valid_r <= 1'b0;
            dst_data_r  <= mcr_pkg::RST_WORD;
        end
        else if (clk_en)
        begin
            dst_valid_r <= in_exec && !load_r && (mode_r == mcr_pkg::MODE_REG);
            if (in_exec && !load_r && (mode_r == mcr_pkg::MODE_REG))
                dst_data_r <= ctrl_rd;
        end
    end

    // ==========================================================
    // Controller registers
    // One flop per register; the status word takes its fields in one edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_word_r         <= mcr_pkg::RST_WORD;
            operating_mode_word_r <= mcr_pkg::RST_WORD;
            stack_pointer_r       <= mcr_pkg::RST_WORD;
            loop_address_r        <= mcr_pkg::RST_WORD;
            loop_count_r          <= mcr_pkg::RST_WORD;
        end
        else if (clk_en)
        begin
            if (wr_stat)
                status_word_r <= stat_nxt;
            if (wr_ctrl && sel_r == mcr_pkg::SEL_OPMODE)
                operating_mode_word_r <= src_r;
            if (wr_ctrl && sel_r == mcr_pkg::SEL_LADDR)
                loop_address_r <= src_r;
            if (wr_ctrl && sel_r == mcr_pkg::SEL_LCOUNT)
                loop_count_r <= src_r;
            if (pop)
                stack_pointer_r <= stack_pointer_r - 32'h0000_0001;
            else if (push)
                stack_pointer_r <= stack_pointer_r + 32'h0000_0001;
            else if (wr_ctrl && sel_r == mcr_pkg::SEL_SPTR)
                stack_pointer_r <= src_r;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n || !clk_en);

    sequence s_reg_issue;
        accept && !bad_op && op_mode == mcr_pkg::MODE_REG;
    endsequence
    sequence s_two_cycles;
        !done_r ##1 done_r;
    endsequence

    a_pop_order:   assert property (pop |=> stack_pointer_r == $past(stack_pointer_r) - 32'h0000_0001) else $error("pop wrong");
    a_push_order:  assert property (push |=> stack_pointer_r == $past(stack_pointer_r) + 32'h0000_0001 && stk_high == $past(src_r)) else $error("push wrong");
    a_cc_load:     assert property (wr_stat |=> status_word_r[7:0] == $past(src_r[7:0])) else $error("cc load");
    a_exc_load:    assert property (wr_stat |=> status_word_r[15:8] == $past(src_r[15:8])) else $error("exc load");
    a_sticky_load: assert property (wr_stat |=> status_word_r[20:16] == $past(src_r[20:16])) else $error("sticky load");
    a_flags_hold:  assert property (!wr_stat |=> $stable(status_word_r)) else $error("flags moved");
    a_disp_addr:   assert property (state_r == mcr_pkg::ST_ADDR && mode_r == mcr_pkg::MODE_DISP |=> mem_addr_r == $past(ea_value) + $past(ext_r)) else $error("disp addr");
    a_imm_word:    assert property (state_r == mcr_pkg::ST_FETCH && ext_valid && mode_r == mcr_pkg::MODE_IMM |=> src_r == $past(ext_word) && state_r == mcr_pkg::ST_EXEC) else $error("imm word");
    a_base_cycles: assert property (s_reg_issue |=> s_two_cycles) else $error("reg move not two cycles");
    a_word_count:  assert property (done_r |-> words_r == mcr_pkg::BASE_WORDS + {1'b0, has_ext(mode_r)}) else $error("word count");
    a_bad_mode:    assert property (accept && !mode_ok |=> error_r && state_r == mcr_pkg::ST_IDLE) else $error("bad mode taken");
    a_reg_copy:    assert property (in_exec && !load_r && mode_r == mcr_pkg::MODE_REG |=> dst_valid_r && dst_data_r == $past(ctrl_rd)) else $error("copy out");
endmodule : control_register_move
`default_nettype wire

// ### hdl/mcr_pkg.sv
// Constants and types shared by the control-register move unit
package mcr_pkg;

    // ==========================================================
    // Control register selection codes
    localparam logic [6:0]  SEL_STATUS   = 7'h79;  // Status word
    localparam logic [6:0]  SEL_OPMODE   = 7'h7A;  // Operating mode word
    localparam logic [6:0]  SEL_SPTR     = 7'h7B;  // Stack pointer
    localparam logic [6:0]  SEL_SHIGH    = 7'h7C;  // Stack high word
    localparam logic [6:0]  SEL_SLOW     = 7'h7D;  // Stack low word
    localparam logic [6:0]  SEL_LADDR    = 7'h7E;  // Loop address
    localparam logic [6:0]  SEL_LCOUNT   = 7'h7F;  // Loop count

    // ==========================================================
    // Status word field layout
    localparam int          CC_LSB       = 0;      // Condition code byte
    localparam int          CC_W         = 8;
    localparam int          EXC_LSB      = 8;      // Exception status bits
    localparam int          EXC_W        = 8;
    localparam int          STICKY_LSB   = 16;     // Sticky flag word
    localparam int          STICKY_W     = 5;

    // ==========================================================
    // Reset values, word width and fixed costs
    localparam int          WORD_W       = 32;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [1:0]  BASE_WORDS   = 2'h1;   // Opcode word alone
    localparam int          BASE_CYCLES  = 2;      // Least execution cycles

    // ==========================================================
    // Operand modes and controller states
    typedef enum logic [2:0] {
        MODE_REG  = 3'b000,   // Register to or from register
        MODE_IMM  = 3'b001,   // Immediate extension word
        MODE_EA   = 3'b010,   // Memory, address from the address unit
        MODE_DISP = 3'b011,   // Memory, register plus long displacement
        MODE_ABS  = 3'b100    // Memory, absolute address word
    } mode_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_ADDR  = 3'b010,
        ST_MEM   = 3'b011,
        ST_EXEC  = 3'b100
    } state_type;

endpackage : mcr_pkg

// ### hdl/mcr_stack.sv
// System stack storage: high and low word arrays
`timescale 1ns/1ps
`default_nettype none
module mcr_stack #(
    parameter int DEPTH_W = 4
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire logic [DEPTH_W-1:0] rd_idx,
    output logic      [31:0]        rd_high,
    output logic      [31:0]        rd_low,
    input  wire logic [DEPTH_W-1:0] wr_idx,
    input  wire logic               wr_high_en,
    input  wire logic               wr_low_en,
    input  wire logic [31:0]        wr_data
);
    // ==========================================================
    // Storage
    logic [31:0] high_mem [2**DEPTH_W];  // Stack high words
    logic [31:0] low_mem  [2**DEPTH_W];  // Stack low words

    // Read is combinational so a pop sees the word before the pointer moves
    assign rd_high = high_mem[rd_idx];
    assign rd_low  = low_mem[rd_idx];

    // Cleared at reset so no read returns an unknown word
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 2**DEPTH_W; i++)
            begin
                high_mem[i] <= mcr_pkg::RST_WORD;
                low_mem[i]  <= mcr_pkg::RST_WORD;
            end
        end
        else if (clk_en)
        begin
            if (wr_high_en)
                high_mem[wr_idx] <= wr_data;
            if (wr_low_en)
                low_mem[wr_idx] <= wr_data;
        end
    end
endmodule : mcr_stack
`default_nettype wire

// ### tb/control_register_move_tb_top.sv
// Self-checking testbench for the control-register move unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module control_register_move_tb_top;
    // =====================================================
    // Stimulus and observation signals
    logic        clk_sys     = 1'b0;      // 50 MHz core clock
    logic        rst_n       = 1'b0;      // Async reset, low active
    logic        clk_en      = 1'b1;      // Run enable
    logic        op_valid    = 1'b0;      // Issue strobe
    logic        op_load     = 1'b0;      // Direction of transfer
    logic [2:0]  op_mode     = 3'h0;      // Operand mode
    logic [6:0]  op_sel      = 7'h00;     // Control register code
    logic        op_space    = 1'b0;      // X or Y memory
    logic [2:0]  op_areg     = 3'h0;      // Address register number
    logic [31:0] op_reg_data = 32'h0;     // Register source word
    logic [31:0] ea_value    = 32'h0;     // Address unit result
    logic        ext_valid   = 1'b0;      // Extension word present
    logic [31:0] ext_word    = 32'h0;
    logic        mem_ack     = 1'b0;      // One-cycle memory answer
    logic [31:0] mem_rdata   = 32'h0;
    wire         op_ready_r, ext_req_r, mem_req_r, mem_we_r, mem_space_r;
    wire         dst_valid_r, done_r, error_r;
    wire  [2:0]  areg_sel_r;
    wire  [1:0]  words_r;
    wire  [31:0] mem_addr_r, mem_wdata_r, dst_data_r, status_word_r;
    wire  [31:0] operating_mode_word_r, stack_pointer_r, loop_address_r, loop_count_r;
    int          error_cnt   = 0;         // Mismatches seen
    int          check_count = 0;         // Comparisons made
    int          tick        = 0;         // Cycles since start
    int          cyc;                     // Cycles from accept to finish
    logic        got_dst, got_err, m_we, m_sp;
    logic [31:0] m_addr, m_wd;
    logic [6:0]  sels [4];
    logic [31:0] outs [4];

    control_register_move #(.DEPTH_W(4)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .op_valid(op_valid),
        .op_ready_r(op_ready_r), .op_load(op_load), .op_mode(op_mode), .op_sel(op_sel),
        .op_space(op_space), .op_areg(op_areg), .op_reg_data(op_reg_data),
        .ea_value(ea_value), .areg_sel_r(areg_sel_r), .ext_req_r(ext_req_r),
        .ext_valid(ext_valid), .ext_word(ext_word), .mem_req_r(mem_req_r),
        .mem_we_r(mem_we_r), .mem_space_r(mem_space_r), .mem_addr_r(mem_addr_r),
        .mem_wdata_r(mem_wdata_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .dst_valid_r(dst_valid_r), .dst_data_r(dst_data_r), .done_r(done_r),
        .error_r(error_r), .words_r(words_r), .status_word_r(status_word_r),
        .operating_mode_word_r(operating_mode_word_r),
        .stack_pointer_r(stack_pointer_r), .loop_address_r(loop_address_r),
        .loop_count_r(loop_count_r)
    );

    // =====================================================
    // Clock and hang guard
    always #10 clk_sys = ~clk_sys;

    // Runs take under a hundred cycles, so 5000 means a hang
    always @(posedge clk_sys)
    begin
        tick++;
        if (tick == 5000)
        begin
            error_cnt++;
            results();
        end
    end

    // =====================================================
    // Tasks
    // Verdict and end of run, the only place the run stops
    task automatic results;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Issue one move at a falling edge, then answer extension and memory requests
    // with no wait until done or error; ack is held one cycle only
    task automatic do_op(input logic ld, input logic [2:0] md, input logic [6:0] sl,
                         input logic [31:0] rd, input logic [31:0] ext,
                         input logic [31:0] mrd);
        int n;
        op_valid    = 1'b1;
        op_load     = ld;
        op_mode     = md;
        op_sel      = sl;
        op_reg_data = rd;
        ext_word    = ext;
        mem_rdata   = mrd;
        got_dst     = 1'b0;
        got_err     = 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        op_valid = 1'b0;
        n = 1;
        forever
        begin
            ext_valid = (ext_req_r === 1'b1);
            mem_ack   = (mem_req_r === 1'b1);
            if (mem_req_r === 1'b1)
            begin
                m_addr = mem_addr_r;
                m_we   = mem_we_r;
                m_sp   = mem_space_r;
                m_wd   = mem_wdata_r;
            end
            if (dst_valid_r === 1'b1) got_dst = 1'b1;
            if (error_r === 1'b1) got_err = 1'b1;
            if (done_r === 1'b1 || error_r === 1'b1 || n > 40) break;
            @(negedge clk_sys);
            n++;
        end
        cyc       = n;
        ext_valid = 1'b0;
        mem_ack   = 1'b0;
    endtask : do_op

    // =====================================================
    // Main sequence
    initial
    begin
        sels = '{mcr_pkg::SEL_OPMODE, mcr_pkg::SEL_SPTR, mcr_pkg::SEL_LADDR,
                 mcr_pkg::SEL_LCOUNT};
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        `CHK("ready", 1'b1, op_ready_r)
        `CHK("status rst", 32'h0, status_word_r)
        `CHK("words rst", 2'h1, words_r)
        // Enable low freezes the unit: a pending status load must not land
        clk_en      = 1'b0;
        op_valid    = 1'b1;
        op_load     = 1'b1;
        op_mode     = 3'h0;
        op_sel      = mcr_pkg::SEL_STATUS;
        op_reg_data = 32'hFFFF_FFFF;
        repeat (3) @(negedge clk_sys);
        `CHK("frozen status", 32'h0, status_word_r)
        `CHK("frozen ready", 1'b1, op_ready_r)
        op_valid = 1'b0;
        clk_en   = 1'b1;
        @(negedge clk_sys);
        // Status load through register mode, fields land together
        do_op(1'b1, 3'h0, mcr_pkg::SEL_STATUS, 32'hABF5_A5C3, 32'h0, 32'h0);
        `CHK("cc", 8'hC3, status_word_r[mcr_pkg::CC_LSB +: mcr_pkg::CC_W])
        `CHK("exc", 8'hA5, status_word_r[mcr_pkg::EXC_LSB +: mcr_pkg::EXC_W])
        `CHK("sticky", 5'h15, status_word_r[mcr_pkg::STICKY_LSB +: 5])
        `CHK("status", 32'hABF5_A5C3, status_word_r)
        `CHK("reg cycles", 2, cyc)
        `CHK("reg words", 2'h1, words_r)
        // Load mode, stack pointer and loop registers back to back, flags must stay put
        for (int i = 0; i < 4; i++)
            do_op(1'b1, 3'h0, sels[i], 32'h5A00_0000 | i, 32'h0, 32'h0);
        outs = '{operating_mode_word_r, stack_pointer_r, loop_address_r, loop_count_r};
        for (int i = 0; i < 4; i++)
            `CHK("loaded", 32'h5A00_0000 | i, outs[i])
        `CHK("flags kept", 32'hABF5_A5C3, status_word_r)
        // Copy the four loaded registers and the status word out to a data register
        for (int i = 0; i < 4; i++)
        begin
            do_op(1'b0, 3'h0, sels[i], 32'h0, 32'h0, 32'h0);
            `CHK("dst valid", 1'b1, got_dst)
            `CHK("copy out", 32'h5A00_0000 | i, dst_data_r)
        end
        do_op(1'b0, 3'h0, mcr_pkg::SEL_STATUS, 32'h0, 32'h0, 32'h0);
        `CHK("status out", 32'hABF5_A5C3, dst_data_r)
        // Stack: push on high-word write, pop after high-word read
        do_op(1'b1, 3'h0, mcr_pkg::SEL_SPTR, 32'h0000_0003, 32'h0, 32'h0);
        do_op(1'b1, 3'h0, mcr_pkg::SEL_SHIGH, 32'hC0DE_0001, 32'h0, 32'h0);
        `CHK("push sp", 32'h0000_0004, stack_pointer_r)
        do_op(1'b1, 3'h0, mcr_pkg::SEL_SLOW, 32'h0000_5107, 32'h0, 32'h0);
        do_op(1'b0, 3'h0, mcr_pkg::SEL_SLOW, 32'h0, 32'h0, 32'h0);
        `CHK("low word", 32'h0000_5107, dst_data_r)
        `CHK("low keeps sp", 32'h0000_0004, stack_pointer_r)
        do_op(1'b0, 3'h0, mcr_pkg::SEL_SHIGH, 32'h0, 32'h0, 32'h0);
        `CHK("high word", 32'hC0DE_0001, dst_data_r)
        `CHK("pop sp", 32'h0000_0003, stack_pointer_r)
        // Immediate into loop count
        do_op(1'b1, 3'h1, mcr_pkg::SEL_LCOUNT, 32'h0, 32'hDEAD_BEEF, 32'h0);
        `CHK("imm", 32'hDEAD_BEEF, loop_count_r)
        `CHK("imm cycles", 3, cyc)
        `CHK("imm words", 2'h2, words_r)
        // X memory read through the address unit into loop address
        op_space = 1'b0;
        op_areg  = 3'h2;
        ea_value = 32'h0000_1234;
        do_op(1'b1, 3'h2, mcr_pkg::SEL_LADDR, 32'h0, 32'h0, 32'h8765_4321);
        `CHK("ea addr", 32'h0000_1234, m_addr)
        `CHK("ea read", 1'b0, m_we)
        `CHK("ea data", 32'h8765_4321, loop_address_r)
        `CHK("ea cycles", 4, cyc)
        `CHK("ea words", 2'h1, words_r)
        // Y memory write with register plus long displacement, highest register
        op_space = 1'b1;
        op_areg  = 3'h7;
        ea_value = 32'h0000_0100;
        do_op(1'b0, 3'h3, mcr_pkg::SEL_OPMODE, 32'h0, 32'hFFFF_FFF0, 32'h0);
        `CHK("disp addr", 32'h0000_00F0, m_addr)
        `CHK("disp areg", 3'h7, areg_sel_r)
        `CHK("disp write", 1'b1, m_we)
        `CHK("disp space", 1'b1, m_sp)
        `CHK("disp data", 32'h5A00_0000, m_wd)
        `CHK("disp cycles", 5, cyc)
        `CHK("disp words", 2'h2, words_r)
        // Absolute read into the status word
        op_space = 1'b0;
        do_op(1'b1, 3'h4, mcr_pkg::SEL_STATUS, 32'h0, 32'h0000_2000, 32'h001F_00FF);
        `CHK("abs addr", 32'h0000_2000, m_addr)
        `CHK("abs status", 32'h001F_00FF, status_word_r)
        `CHK("abs cycles", 4, cyc)
        // Illegal mode and illegal code are refused with nothing changed
        do_op(1'b1, 3'h5, mcr_pkg::SEL_LCOUNT, 32'h1, 32'h0, 32'h0);
        `CHK("bad mode", 1'b1, got_err)
        do_op(1'b1, 3'h0, 7'h00, 32'h1, 32'h0, 32'h0);
        `CHK("bad code", 1'b1, got_err)
        `CHK("count kept", 32'hDEAD_BEEF, loop_count_r)
        `CHK("status kept", 32'h001F_00FF, status_word_r)
        results();
    end
endmodule : control_register_move_tb_top
`undef CHK
`default_nettype wire
